// ---- src/dlf_flash_prog_top.sv ----
// Flash programming control and data registers behind the debug link
module dlf_flash_prog_top #(
    parameter int FIFO_W = 11
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Core state
    input wire logic core_halted,
    // Link pins
    input wire logic debug_link_clock_pin,
    input wire logic debug_link_data_pin_i,
    output logic debug_link_data_pin_o_ff,
    output logic debug_link_data_pin_oe_ff,
    // Flash engine stream
    output logic fl_valid_ff,
    output logic [7:0] fl_byte_ff,
    output logic fl_is_cmd_ff,
    output logic [1:0] fl_cmd_ff,
    input wire logic fl_ready,
    input wire logic fl_cmd_done,
    input wire logic fl_rdata_valid,
    input wire logic [7:0] fl_rdata,
    output logic fl_rd_taken_ff,
    // Mode
    output logic prog_mode_ff
);
    logic wr_pulse, rd_pulse;
    logic [1:0] ins;
    logic [7:0] lbyte;
    logic [7:0] addr_sel_ff, nxt_addr_sel;
    logic [7:0] flash_program_control_ff, nxt_ctl;
    logic [7:0] flash_program_data_ff, nxt_dat;
    dlf_pkg::dlf_unlock_e state_ff, nxt_state;
    logic expect_cmd_ff, nxt_expect_cmd;
    logic nxt_rd_taken;
    logic [FIFO_W-1:0] slot_ff [2];
    logic [1:0] sv_ff;
    logic [FIFO_W-1:0] nxt_slot [2];
    logic [1:0] nxt_sv;
    logic [FIFO_W-1:0] push_word;
    logic push, pop, full, ack_ok, wr_ctl, wr_dat;
    logic [2:0] dec;
    logic [7:0] rd_data_byte;

    // Command byte to {valid, code}
    function automatic logic [2:0] cmd_decode(input logic [7:0] b);
        case (b)
            dlf_pkg::CMD_BLOCK_READ: cmd_decode = {1'b1, dlf_pkg::CODE_BLOCK_READ};
            dlf_pkg::CMD_BLOCK_WRITE: cmd_decode = {1'b1, dlf_pkg::CODE_BLOCK_WRITE};
            dlf_pkg::CMD_PAGE_ERASE: cmd_decode = {1'b1, dlf_pkg::CODE_PAGE_ERASE};
            dlf_pkg::CMD_DEVICE_ERASE: cmd_decode = {1'b1, dlf_pkg::CODE_DEVICE_ERASE};
            default: cmd_decode = 3'h0;
        endcase
    endfunction : cmd_decode

    dlf_link_rx dlf_link_rx_inst (
        .core_clk(core_clk),
        .rstn(rstn),
        .core_halted(core_halted),
        .clk_pin_i(debug_link_clock_pin),
        .dat_pin_i(debug_link_data_pin_i),
        .dat_pin_o_ff(debug_link_data_pin_o_ff),
        .dat_pin_oe_ff(debug_link_data_pin_oe_ff),
        .rd_addr_byte(addr_sel_ff),
        .rd_data_byte(rd_data_byte),
        .ack_ok(ack_ok),
        .wr_pulse_ff(wr_pulse),
        .rd_pulse_ff(rd_pulse),
        .ins_ff(ins),
        .byte_ff(lbyte)
    );

    // Register decode and unlock sequence
    always_comb begin
        wr_ctl = wr_pulse && ins == dlf_pkg::INS_DATA_WRITE &&
            addr_sel_ff == dlf_pkg::ADDR_CONTROL; // RULE5 RULE8
        wr_dat = wr_pulse && ins == dlf_pkg::INS_DATA_WRITE &&
            addr_sel_ff == dlf_pkg::ADDR_DATA; // RULE6 RULE8
        case (addr_sel_ff)
            dlf_pkg::ADDR_CONTROL: rd_data_byte = flash_program_control_ff; // RULE5
            dlf_pkg::ADDR_DATA: rd_data_byte = flash_program_data_ff; // RULE6
            default: rd_data_byte = 8'h00;
        endcase
        full = sv_ff[0] && sv_ff[1];
        // Only a data write can be refused; address write frames always acknowledge
        ack_ok = !(ins == dlf_pkg::INS_DATA_WRITE && addr_sel_ff == dlf_pkg::ADDR_DATA &&
            state_ff == dlf_pkg::ST_PROG && full);
        nxt_addr_sel = addr_sel_ff;
        if (wr_pulse && ins == dlf_pkg::INS_ADDR_WRITE) begin
            nxt_addr_sel = lbyte;
        end
        nxt_ctl = wr_ctl ? lbyte : flash_program_control_ff;
        nxt_state = state_ff;
        if (wr_ctl) begin
            case (state_ff) // RULE1
                dlf_pkg::ST_LOCKED: begin
                    if (lbyte == dlf_pkg::UNLOCK_FIRST) begin
                        nxt_state = dlf_pkg::ST_HALF;
                    end
                end
                dlf_pkg::ST_HALF: begin
                    if (lbyte == dlf_pkg::UNLOCK_SECOND) begin
                        nxt_state = dlf_pkg::ST_PROG;
                    end else if (lbyte != dlf_pkg::UNLOCK_FIRST) begin
                        nxt_state = dlf_pkg::ST_LOCKED; // RULE9
                    end
                end
                dlf_pkg::ST_PROG: nxt_state = dlf_pkg::ST_PROG; // RULE2
                default: nxt_state = dlf_pkg::ST_LOCKED;
            endcase
        end
        nxt_dat = flash_program_data_ff;
        if (wr_dat) begin
            nxt_dat = lbyte; // RULE3
        end else if (fl_rdata_valid) begin
            nxt_dat = fl_rdata; // RULE3
        end
        nxt_rd_taken = rd_pulse && ins == dlf_pkg::INS_DATA_READ &&
            addr_sel_ff == dlf_pkg::ADDR_DATA;
    end

    // Command decode and two-entry buffer toward the flash engine
    always_comb begin
        dec = cmd_decode(lbyte); // RULE4
        nxt_expect_cmd = expect_cmd_ff;
        push = 1'b0;
        push_word = {1'b0, 2'h0, lbyte};
        // Push only what the host was told was accepted, even if a pop freed room since
        if (wr_dat && state_ff == dlf_pkg::ST_PROG && debug_link_data_pin_o_ff) begin // RULE9
            if (expect_cmd_ff) begin
                if (dec[2]) begin // RULE4
                    push = 1'b1;
                    push_word = {1'b1, dec[1:0], lbyte};
                    nxt_expect_cmd = 1'b0;
                end
            end else begin
                push = 1'b1;
            end
        end
        if (fl_cmd_done) begin
            nxt_expect_cmd = 1'b1;
        end
        pop = sv_ff[0] && fl_ready;
        nxt_slot[0] = slot_ff[0];
        nxt_slot[1] = slot_ff[1];
        nxt_sv = sv_ff;
        if (pop) begin
            nxt_slot[0] = slot_ff[1];
            nxt_sv = {1'b0, sv_ff[1]};
        end
        if (push) begin
            if (!nxt_sv[0]) begin
                nxt_slot[0] = push_word;
                nxt_sv[0] = 1'b1;
            end else begin
                nxt_slot[1] = push_word;
                nxt_sv[1] = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            addr_sel_ff <= dlf_pkg::ADDR_SEL_RESET;
            flash_program_control_ff <= dlf_pkg::CONTROL_RESET; // RULE5
            flash_program_data_ff <= dlf_pkg::DATA_RESET; // RULE6
            state_ff <= dlf_pkg::ST_LOCKED; // RULE2
            prog_mode_ff <= 1'b0;
            expect_cmd_ff <= 1'b1;
            fl_rd_taken_ff <= 1'b0;
            slot_ff[0] <= '0;
            slot_ff[1] <= '0;
            sv_ff <= 2'h0;
            fl_valid_ff <= 1'b0;
            fl_byte_ff <= 8'h00;
            fl_is_cmd_ff <= 1'b0;
            fl_cmd_ff <= 2'h0;
        end else begin
            addr_sel_ff <= nxt_addr_sel;
            flash_program_control_ff <= nxt_ctl;
            flash_program_data_ff <= nxt_dat;
            state_ff <= nxt_state;
            prog_mode_ff <= (nxt_state == dlf_pkg::ST_PROG);
            expect_cmd_ff <= nxt_expect_cmd;
            fl_rd_taken_ff <= nxt_rd_taken;
            slot_ff[0] <= nxt_slot[0];
            slot_ff[1] <= nxt_slot[1];
            sv_ff <= nxt_sv;
            fl_valid_ff <= nxt_sv[0];
            fl_byte_ff <= nxt_slot[0][7:0];
            fl_is_cmd_ff <= nxt_slot[0][10];
            fl_cmd_ff <= nxt_slot[0][9:8];
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    unlock_enter_a: assert property (wr_ctl && state_ff == dlf_pkg::ST_HALF &&
            lbyte == dlf_pkg::UNLOCK_SECOND |=> prog_mode_ff) // RULE2
        else $error("Unlock sequence did not enter programming");
    prog_sticky_a: assert property (prog_mode_ff |=> prog_mode_ff) // RULE2
        else $error("Programming mode left without reset");
    ctl_store_a: assert property (wr_ctl |=> flash_program_control_ff == $past(lbyte)) // RULE5
        else $error("Control register write lost");
    dat_store_a: assert property (wr_dat |=> flash_program_data_ff == $past(lbyte)) // RULE6
        else $error("Data register write lost");
    locked_nopush_a: assert property (state_ff != dlf_pkg::ST_PROG |-> !push) // RULE9
        else $error("Command passed before unlock");
    cmd_map_a: assert property (push && expect_cmd_ff && lbyte == dlf_pkg::CMD_PAGE_ERASE
            && !sv_ff[0] |=> fl_valid_ff && fl_is_cmd_ff
            && fl_cmd_ff == dlf_pkg::CODE_PAGE_ERASE) // RULE4
        else $error("Page erase command decoded wrongly");
    bad_cmd_a: assert property (wr_dat && expect_cmd_ff && !dec[2] |-> !push) // RULE4
        else $error("Unknown command byte forwarded");
    stall_hold_a: assert property (fl_valid_ff && !fl_ready |=> fl_valid_ff
            && $stable(fl_byte_ff)) // RULE3
        else $error("Buffered byte lost during stall");
    cover_unlock_c: cover property (!prog_mode_ff ##1 prog_mode_ff);
    cover_full_c: cover property (full && wr_dat);
    cover_cmd_c: cover property (fl_valid_ff && fl_is_cmd_ff && fl_ready);
endmodule : dlf_flash_prog_top

// ---- inc/dlf_pkg.sv ----
// Constants shared by the debug link flash programming block
// Behaviour
// RULE1 - Host unlocks by writing 0x02 then 0x01
// RULE2 - Unlocked mode holds until system reset
// RULE3 - One 8-bit data register carries everything
// RULE4 - Decode 0x06 read, 0x07 write, 0x08, 0x03
// RULE5 - Control register at address 0x02, resets zero
// RULE6 - Data register at address 0xb4, resets zero
// RULE7 - Link works only while core is halted
// RULE8 - Host selects target address before each access
// RULE9 - Commands ignored until unlock sequence completes
package dlf_pkg;
    localparam logic [7:0] ADDR_CONTROL = 8'h02;
    localparam logic [7:0] ADDR_DATA = 8'hb4;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] ADDR_SEL_RESET = 8'h00;
    localparam logic [7:0] UNLOCK_FIRST = 8'h02;
    localparam logic [7:0] UNLOCK_SECOND = 8'h01;
    localparam logic [7:0] CMD_BLOCK_READ = 8'h06;
    localparam logic [7:0] CMD_BLOCK_WRITE = 8'h07;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h08;
    localparam logic [7:0] CMD_DEVICE_ERASE = 8'h03;
    localparam logic [1:0] CODE_BLOCK_READ = 2'h0;
    localparam logic [1:0] CODE_BLOCK_WRITE = 2'h1;
    localparam logic [1:0] CODE_PAGE_ERASE = 2'h2;
    localparam logic [1:0] CODE_DEVICE_ERASE = 2'h3;
    localparam logic [1:0] INS_DATA_READ = 2'h0;
    localparam logic [1:0] INS_DATA_WRITE = 2'h1;
    localparam logic [1:0] INS_ADDR_WRITE = 2'h2;
    localparam logic [1:0] INS_ADDR_READ = 2'h3;
    localparam logic [3:0] CNT_INS_LAST = 4'h1;
    localparam logic [3:0] CNT_DATA_LAST = 4'h9;
    localparam logic [3:0] CNT_ACK = 4'ha;
    typedef enum logic [1:0] {
        ST_LOCKED = 2'b00,
        ST_HALF = 2'b01,
        ST_PROG = 2'b10
    } dlf_unlock_e;
endpackage : dlf_pkg

// ---- src/dlf_link_rx.sv ----
// Pin sampling and bit framing of the debug link
module dlf_link_rx (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Core state
    input wire logic core_halted,
    // Link pins
    input wire logic clk_pin_i,
    input wire logic dat_pin_i,
    output logic dat_pin_o_ff,
    output logic dat_pin_oe_ff,
    // Frame results
    input wire logic [7:0] rd_addr_byte,
    input wire logic [7:0] rd_data_byte,
    input wire logic ack_ok,
    output logic wr_pulse_ff,
    output logic rd_pulse_ff,
    output logic [1:0] ins_ff,
    output logic [7:0] byte_ff
);
    logic [2:0] clk_s_ff, nxt_clk_s;
    logic [2:0] dat_s_ff, nxt_dat_s;
    logic clk_c_ff, nxt_clk_c;
    logic dat_c_ff, nxt_dat_c;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [7:0] sh_ff, nxt_sh;
    logic nxt_o, nxt_oe, nxt_wr, nxt_rd;
    logic [1:0] nxt_ins;
    logic [7:0] nxt_byte;
    logic rise;

    always_comb begin
        nxt_clk_s = {clk_s_ff[1:0], clk_pin_i};
        nxt_dat_s = {dat_s_ff[1:0], dat_pin_i};
        nxt_clk_c = (clk_s_ff[1] == clk_s_ff[2]) ? clk_s_ff[2] : clk_c_ff;
        nxt_dat_c = (dat_s_ff[1] == dat_s_ff[2]) ? dat_s_ff[2] : dat_c_ff;
        rise = nxt_clk_c && !clk_c_ff;
        nxt_cnt = cnt_ff;
        nxt_sh = sh_ff;
        nxt_o = dat_pin_o_ff;
        nxt_oe = dat_pin_oe_ff;
        nxt_wr = 1'b0;
        nxt_rd = 1'b0;
        nxt_ins = ins_ff;
        nxt_byte = byte_ff;
        if (!core_halted) begin // RULE7
            nxt_cnt = 4'h0;
            nxt_oe = 1'b0;
        end else if (rise) begin
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff <= dlf_pkg::CNT_INS_LAST) begin
                nxt_ins = {ins_ff[0], dat_c_ff};
                if (cnt_ff == dlf_pkg::CNT_INS_LAST &&
                        (nxt_ins == dlf_pkg::INS_DATA_READ ||
                        nxt_ins == dlf_pkg::INS_ADDR_READ)) begin
                    nxt_sh = (nxt_ins == dlf_pkg::INS_ADDR_READ) ? rd_addr_byte : rd_data_byte;
                    nxt_o = nxt_sh[7];
                    nxt_oe = 1'b1;
                end
            end else if (cnt_ff == dlf_pkg::CNT_ACK) begin
                nxt_oe = 1'b0;
                nxt_cnt = 4'h0;
            end else if (ins_ff == dlf_pkg::INS_DATA_READ ||
                    ins_ff == dlf_pkg::INS_ADDR_READ) begin
                nxt_sh = {sh_ff[6:0], 1'b0};
                nxt_o = nxt_sh[7];
                if (cnt_ff == dlf_pkg::CNT_DATA_LAST) begin
                    nxt_oe = 1'b0;
                    nxt_cnt = 4'h0;
                    nxt_rd = 1'b1;
                end
            end else begin
                nxt_sh = {sh_ff[6:0], dat_c_ff};
                if (cnt_ff == dlf_pkg::CNT_DATA_LAST) begin
                    nxt_byte = nxt_sh;
                    nxt_wr = 1'b1;
                    nxt_o = ack_ok;
                    nxt_oe = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            clk_s_ff <= 3'h0;
            dat_s_ff <= 3'h0;
            clk_c_ff <= 1'b0;
            dat_c_ff <= 1'b0;
            cnt_ff <= 4'h0;
            sh_ff <= 8'h00;
            dat_pin_o_ff <= 1'b0;
            dat_pin_oe_ff <= 1'b0;
            wr_pulse_ff <= 1'b0;
            rd_pulse_ff <= 1'b0;
            ins_ff <= 2'h0;
            byte_ff <= 8'h00;
        end else begin
            clk_s_ff <= nxt_clk_s;
            dat_s_ff <= nxt_dat_s;
            clk_c_ff <= nxt_clk_c;
            dat_c_ff <= nxt_dat_c;
            cnt_ff <= nxt_cnt;
            sh_ff <= nxt_sh;
            dat_pin_o_ff <= nxt_o;
            dat_pin_oe_ff <= nxt_oe;
            wr_pulse_ff <= nxt_wr;
            rd_pulse_ff <= nxt_rd;
            ins_ff <= nxt_ins;
            byte_ff <= nxt_byte;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    halt_release_a: assert property (!core_halted |=> !dat_pin_oe_ff) // RULE7
        else $error("Data pin driven while core running");
    halt_nowrite_a: assert property (!core_halted |=> !wr_pulse_ff) // RULE7
        else $error("Frame accepted while core running");
endmodule : dlf_link_rx

// ---- verification/dlf_host_model.sv ----
// Host adapter model that drives the debug link pins
module dlf_host_model (
    // Device side of the data pin
    input wire logic dev_o,
    input wire logic dev_oe,
    // Link pins
    output logic clk_pin,
    output wire logic dat_level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic host_oe;
    logic host_dat;
    // Pull-up holds the data line high when nobody drives it
    assign dat_level = dev_oe ? dev_o : (host_oe ? host_dat : 1'b1);
    initial begin
        clk_pin = 1'b0;
        host_oe = 1'b0;
        host_dat = 1'b1;
    end
    // One clock pulse: low half then high half
    task automatic pulse();
        #200 clk_pin = 1'b1;
        #200 clk_pin = 1'b0;
    endtask : pulse
    // Sample just before a rise, then give the rise
    task automatic sample_pulse(output logic v);
        #190 v = dat_level;
        #10 clk_pin = 1'b1;
        #200 clk_pin = 1'b0;
    endtask : sample_pulse
    // Whole frame; clock stands low outside frames
    task automatic frame(input logic [1:0] ins, input logic [7:0] wbyte,
                         output logic [7:0] rbyte, output logic ack);
        rbyte = 8'h00;
        ack = 1'b1;
        #7;
        host_oe = 1'b1;
        for (int i = 1; i >= 0; i--) begin
            host_dat = ins[i];
            pulse();
        end
        if (ins[0] == ins[1]) begin
            host_oe = 1'b0;
            for (int i = 7; i >= 0; i--) begin
                sample_pulse(rbyte[i]);
            end
        end else begin
            for (int i = 7; i >= 0; i--) begin
                host_dat = wbyte[i];
                pulse();
            end
            host_oe = 1'b0;
            sample_pulse(ack);
        end
        #200;
    endtask : frame
endmodule : dlf_host_model

// ---- verification/test_dlf_flash_prog_top.sv ----
// Self-checking bench for the flash programming registers
module test_dlf_flash_prog_top;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected %s: expected %h, seen %h", nm, (e), (g)); end end
    logic core_clk, rstn, core_halted, fl_ready, fl_cmd_done, fl_rdata_valid;
    logic [7:0] fl_rdata, fl_byte, rb;
    logic link_clk, link_dat, dat_o, dat_oe, fl_valid, fl_is_cmd, fl_rd_taken, prog_mode, ak;
    logic [1:0] fl_cmd;
    logic [10:0] popped[$];
    int n_mismatch, num_checks, n_rd_taken;
    dlf_flash_prog_top #(.FIFO_W(11)) dlf_flash_prog_top_inst (
        .core_clk(core_clk), .rstn(rstn), .core_halted(core_halted),
        .debug_link_clock_pin(link_clk), .debug_link_data_pin_i(link_dat),
        .debug_link_data_pin_o_ff(dat_o), .debug_link_data_pin_oe_ff(dat_oe),
        .fl_valid_ff(fl_valid), .fl_byte_ff(fl_byte), .fl_is_cmd_ff(fl_is_cmd),
        .fl_cmd_ff(fl_cmd), .fl_ready(fl_ready), .fl_cmd_done(fl_cmd_done),
        .fl_rdata_valid(fl_rdata_valid), .fl_rdata(fl_rdata),
        .fl_rd_taken_ff(fl_rd_taken), .prog_mode_ff(prog_mode));
    dlf_host_model dlf_host_model_inst (
        .dev_o(dat_o), .dev_oe(dat_oe), .clk_pin(link_clk), .dat_level(link_dat));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Flash engine side: records every popped entry
    always @(posedge core_clk) begin
        if (fl_valid === 1'b1 && fl_ready === 1'b1) popped.push_back({fl_is_cmd, fl_cmd, fl_byte});
        if (fl_rd_taken === 1'b1) n_rd_taken++;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic exp_ack);
        dlf_host_model_inst.frame(dlf_pkg::INS_ADDR_WRITE, a, rb, ak);
        `CHK("addr_ack", 1'b1, ak)
        dlf_host_model_inst.frame(dlf_pkg::INS_DATA_WRITE, d, rb, ak);
        `CHK("ack", exp_ack, ak)
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        dlf_host_model_inst.frame(dlf_pkg::INS_ADDR_WRITE, a, rb, ak);
        `CHK("addr_ack", 1'b1, ak)
        dlf_host_model_inst.frame(dlf_pkg::INS_DATA_READ, 8'h00, rb, ak);
        `CHK("read", exp, rb)
    endtask : rd
    task automatic do_reset();
        @(posedge core_clk) #1 rstn = 1'b0;
        repeat (4) @(posedge core_clk);
        #1 rstn = 1'b1;
        repeat (6) @(posedge core_clk);
    endtask : do_reset
    task automatic cmd_done();
        @(posedge core_clk) #1 fl_cmd_done = 1'b1;
        @(posedge core_clk) #1 fl_cmd_done = 1'b0;
    endtask : cmd_done
    task automatic t_reset();
        `CHK("prog_mode", 1'b0, prog_mode)
        rd(dlf_pkg::ADDR_CONTROL, dlf_pkg::CONTROL_RESET);
        rd(dlf_pkg::ADDR_DATA, dlf_pkg::DATA_RESET);
        rd(8'h33, 8'h00);
        dlf_host_model_inst.frame(dlf_pkg::INS_ADDR_READ, 8'h00, rb, ak);
        `CHK("addr_read", 8'h33, rb)
    endtask : t_reset
    task automatic t_not_halted();
        @(posedge core_clk) #1 core_halted = 1'b0;
        wr(dlf_pkg::ADDR_DATA, 8'h99, 1'b1);
        rd(dlf_pkg::ADDR_DATA, 8'hff);
        @(posedge core_clk) #1 core_halted = 1'b1;
        repeat (6) @(posedge core_clk);
        rd(dlf_pkg::ADDR_DATA, 8'h00);
    endtask : t_not_halted
    task automatic t_locked();
        wr(dlf_pkg::ADDR_DATA, dlf_pkg::CMD_BLOCK_WRITE, 1'b1);
        rd(dlf_pkg::ADDR_DATA, dlf_pkg::CMD_BLOCK_WRITE);
        `CHK("no_forward", 0, popped.size())
        wr(dlf_pkg::ADDR_CONTROL, 8'h02, 1'b1);
        wr(dlf_pkg::ADDR_CONTROL, 8'h5a, 1'b1);
        wr(dlf_pkg::ADDR_CONTROL, 8'h01, 1'b1);
        `CHK("prog_mode", 1'b0, prog_mode)
        rd(dlf_pkg::ADDR_CONTROL, 8'h01);
        wr(dlf_pkg::ADDR_CONTROL, 8'h02, 1'b1);
        `CHK("prog_mode", 1'b0, prog_mode)
        wr(dlf_pkg::ADDR_CONTROL, 8'h02, 1'b1);
        wr(dlf_pkg::ADDR_CONTROL, 8'h01, 1'b1);
        `CHK("prog_mode", 1'b1, prog_mode)
    endtask : t_locked
    task automatic t_cmds();
        logic [7:0] cmds[4] = '{dlf_pkg::CMD_BLOCK_READ, dlf_pkg::CMD_BLOCK_WRITE,
                                dlf_pkg::CMD_PAGE_ERASE, dlf_pkg::CMD_DEVICE_ERASE};
        logic [1:0] codes[4] = '{dlf_pkg::CODE_BLOCK_READ, dlf_pkg::CODE_BLOCK_WRITE,
                                 dlf_pkg::CODE_PAGE_ERASE, dlf_pkg::CODE_DEVICE_ERASE};
        @(posedge core_clk) #1 fl_ready = 1'b1;
        wr(dlf_pkg::ADDR_DATA, 8'h55, 1'b1);
        for (int k = 0; k < 4; k++) begin
            wr(dlf_pkg::ADDR_DATA, cmds[k], 1'b1);
            wr(dlf_pkg::ADDR_DATA, 8'ha0 + 8'(k), 1'b1);
            cmd_done();
        end
        `CHK("pops", 8, popped.size())
        for (int k = 0; k < 4; k++) begin
            `CHK("cmd", {1'b1, codes[k], cmds[k]}, popped[2*k])
            `CHK("byte", {1'b0, 8'ha0 + 8'(k)}, {popped[2*k+1][10], popped[2*k+1][7:0]})
        end
    endtask : t_cmds
    task automatic t_full();
        int n0;
        @(posedge core_clk) #1 fl_ready = 1'b0;
        n0 = popped.size();
        wr(dlf_pkg::ADDR_DATA, dlf_pkg::CMD_BLOCK_WRITE, 1'b1);
        wr(dlf_pkg::ADDR_DATA, 8'h11, 1'b1);
        wr(dlf_pkg::ADDR_DATA, 8'h22, 1'b0);
        rd(dlf_pkg::ADDR_DATA, 8'h22);
        `CHK("held", n0, popped.size())
        `CHK("valid", 1'b1, fl_valid)
        @(posedge core_clk) #1 fl_ready = 1'b1;
        repeat (4) @(posedge core_clk);
        `CHK("drained", n0 + 2, popped.size())
        `CHK("head", {1'b1, dlf_pkg::CODE_BLOCK_WRITE, dlf_pkg::CMD_BLOCK_WRITE}, popped[n0])
        `CHK("next", 8'h11, popped[n0 + 1][7:0])
        cmd_done();
    endtask : t_full
    task automatic t_rdata();
        n_rd_taken = 0;
        @(posedge core_clk) #1 fl_rdata = 8'hc3;
        fl_rdata_valid = 1'b1;
        @(posedge core_clk) #1 fl_rdata_valid = 1'b0;
        rd(dlf_pkg::ADDR_DATA, 8'hc3);
        repeat (8) @(posedge core_clk);
        `CHK("rd_taken", 1, n_rd_taken)
    endtask : t_rdata
    task automatic t_sysreset();
        wr(dlf_pkg::ADDR_CONTROL, 8'h00, 1'b1);
        `CHK("prog_mode", 1'b1, prog_mode)
        do_reset();
        `CHK("prog_mode", 1'b0, prog_mode)
        rd(dlf_pkg::ADDR_CONTROL, dlf_pkg::CONTROL_RESET);
    endtask : t_sysreset
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude
    initial begin
        #2000000;
        n_mismatch++;
        conclude();
    end
    initial begin
        rstn = 1'b0;
        core_halted = 1'b1;
        fl_ready = 1'b0;
        fl_cmd_done = 1'b0;
        fl_rdata_valid = 1'b0;
        fl_rdata = 8'h00;
        do_reset();
        t_reset();
        t_not_halted();
        t_locked();
        t_cmds();
        t_full();
        t_rdata();
        t_sysreset();
        conclude();
    end
endmodule : test_dlf_flash_prog_top
